// >>> logic/esf_pkg.sv
// Package with register map, field positions, reset values and types of the error/status bank.
package esf_pkg;
   localparam int unsigned ADDR_W = 12;
   // Register indices; byte address is four times the index.
   localparam logic [9:0] IDX_TERM     = 10'h18a;
   localparam logic [9:0] IDX_CODE     = 10'h190;
   localparam logic [9:0] IDX_FATAL    = 10'h191;
   localparam logic [9:0] IDX_NONFATAL = 10'h192;
   localparam logic [9:0] IDX_CTRL     = 10'h1a0;
   localparam logic [9:0] IDX_LIMIT    = 10'h1a1;
   localparam logic [9:0] IDX_ISTAT    = 10'h1a2;
   localparam logic [9:0] IDX_IMASK    = 10'h1a3;
   // Fatal word bits.
   localparam int unsigned FAT_ALARM    = 6;
   localparam int unsigned FAT_CYCLE    = 8;
   localparam int unsigned FAT_PROG     = 9;
   localparam int unsigned FAT_IOSET    = 10;
   localparam int unsigned FAT_MISMATCH = 11;
   localparam int unsigned FAT_DUP      = 13;
   localparam int unsigned FAT_IOBUS    = 14;
   localparam int unsigned FAT_MEM      = 15;
   // Non-fatal word bits.
   localparam int unsigned NF_MMON    = 5;
   localparam int unsigned NF_SPIO    = 6;
   localparam int unsigned NF_CPUBUS  = 7;
   localparam int unsigned NF_CMWDT   = 8;
   localparam int unsigned NF_SETUP   = 10;
   localparam int unsigned NF_CMFATAL = 14;
   localparam int unsigned NF_ALARM   = 15;
   // Control, interrupt fields.
   localparam int unsigned CTRL_CLR     = 0;
   localparam int unsigned CTRL_ROLE    = 1;
   localparam int unsigned INT_FATAL    = 0;
   localparam int unsigned INT_NONFATAL = 1;
   localparam int unsigned INT_W        = 2;
   localparam logic [3:0]  MAX_MOTION_MODULES = 4'h4;
   // Reset values.
   localparam logic [15:0]      RST_CODE  = 16'h0000;
   localparam logic [15:0]      RST_LIMIT = 16'hffff;
   localparam logic [INT_W-1:0] RST_MASK  = 2'h0;
   localparam logic [15:0]      RST_FLAGS = 16'h0000;
   // System error codes are the base OR-ed with the flag bit number.
   localparam logic [15:0] CODE_FATAL_BASE    = 16'h0080;
   localparam logic [15:0] CODE_NONFATAL_BASE = 16'h0040;
   // Fatal conditions after which the controller halts.
   localparam logic [15:0] FATAL_STOP_MASK = 16'hc240;
   typedef enum logic {ESF_RUN = 1'b0, ESF_HALT = 1'b1} esf_run_t;
endpackage : esf_pkg

// >>> logic/esf_sticky_flags.sv
// Bank of sticky flag bits where a set always wins over a clear.
`timescale 1ns/1ns
`default_nettype none
module esf_sticky_flags
   import esf_pkg::*;
#(
   parameter int unsigned W = 16
) (
   input  wire logic         clk,
   input  wire logic         reset,
   input  wire logic [W-1:0] setBits,
   input  wire logic [W-1:0] clrBits,
   output var  logic [W-1:0] flags
);
   typedef struct packed {
      logic [W-1:0] flag_reg;
   } esf_sticky_t;

   esf_sticky_t st;
   esf_sticky_t st_next;

   logic [W-1:0] flag_next;

   // Each bit is independent, so a per-bit loop keeps the set-over-clear priority local.
   for (genvar i = 0; i < W; i++) begin : g_bit
      assign flag_next[i] = setBits[i] | (st.flag_reg[i] & ~clrBits[i]);
   end

   always_comb begin
      st_next          = st;
      st_next.flag_reg = flag_next;
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= st_next;
      end
   end

   assign flags = st.flag_reg;
endmodule : esf_sticky_flags
`default_nettype wire

// >>> logic/esf_code_pick.sv
// Chooses the error code to record from the newly raised fatal and non-fatal flags.
`timescale 1ns/1ns
`default_nettype none
module esf_code_pick
   import esf_pkg::*;
(
   input  wire logic [15:0] newFatal,
   input  wire logic [15:0] newNonfatal,
   input  wire logic [15:0] fatalAlarmCode,
   input  wire logic [15:0] nonfatalAlarmCode,
   output var  logic        codeValid,
   output var  logic [15:0] codeValue
);
   function automatic logic [3:0] top_bit(input logic [15:0] v);
      logic [3:0] idx;
      idx = 4'h0;
      for (int k = 0; k < 16; k++) begin
         if (v[k]) begin
            idx = 4'(k);
         end
      end
      return idx;
   endfunction : top_bit

   logic [3:0] fIdx;
   logic [3:0] nIdx;

   // A fatal error outranks a non-fatal one raised in the same cycle.
   always_comb begin
      fIdx      = top_bit(newFatal);
      nIdx      = top_bit(newNonfatal);
      codeValid = |{newFatal, newNonfatal};
      codeValue = RST_CODE;
      if (|newFatal) begin
         if (fIdx == 4'(FAT_ALARM)) begin
            codeValue = fatalAlarmCode;
         end else begin
            codeValue = CODE_FATAL_BASE | {12'h000, fIdx};
         end
      end else if (|newNonfatal) begin
         if (nIdx == 4'(NF_ALARM)) begin
            codeValue = nonfatalAlarmCode;
         end else begin
            codeValue = CODE_NONFATAL_BASE | {12'h000, nIdx};
         end
      end
   end
endmodule : esf_code_pick
`default_nettype wire

// >>> logic/esf_status_bank.sv
// Error, flag and terminal link status bank with APB register access and interrupt.
`timescale 1ns/1ns
`default_nettype none
module esf_status_bank
   import esf_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              reset,
   // APB slave.
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic [31:0]       pwdata,
   output var  logic [31:0]       prdata,
   output var  logic              pready,
   output var  logic              pslverr,
   // Operator terminal link.
   input  wire logic              terminalLinkMode,
   input  wire logic [7:0]        terminalActive,
   input  wire logic              priorityValid,
   input  wire logic [2:0]        priorityUnit,
   // Alarm instructions.
   input  wire logic              fatalAlarmExec,
   input  wire logic [15:0]       fatalAlarmCode,
   input  wire logic              nonfatalAlarmExec,
   input  wire logic [15:0]       nonfatalAlarmCode,
   // Fatal detectors.
   input  wire logic              cycleDone,
   input  wire logic [15:0]       cycleTimeMeas,
   input  wire logic              programInvalid,
   input  wire logic [3:0]        motionModuleCount,
   input  wire logic              ioModelMismatch,
   input  wire logic              cpuBusUnitDup,
   input  wire logic              specialIoUnitDup,
   input  wire logic              basicIoWordDup,
   input  wire logic              ioBusTransferErr,
   input  wire logic              memoryErr,
   // Non-fatal detectors.
   input  wire logic              motionModuleSysErr,
   input  wire logic              specialIoExchErr,
   input  wire logic              cpuBusExchErr,
   input  wire logic              coordWatchdogTimeout,
   input  wire logic              setupParamErr,
   input  wire logic              coordFatalErr,
   // Results.
   output var  logic              stopOperation,
   output var  logic              errIndicator,
   output var  logic              irq
);
   typedef struct packed {
      logic [31:0]      prdata_reg;
      logic [15:0]      term_reg;
      logic [15:0]      code_reg;
      logic             role_reg;
      logic [15:0]      limit_reg;
      logic [INT_W-1:0] imask_reg;
      logic [INT_W-1:0] icapt_reg;
      esf_run_t         run_reg;
   } esf_bank_t;

   esf_bank_t st;
   esf_bank_t st_next;

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
      return a[ADDR_W-1:2] == idx;
   endfunction : hit

   logic [15:0]      fatalSet;
   logic [15:0]      nonfatalSet;
   logic [15:0]      fatalFlags;
   logic [15:0]      nonfatalFlags;
   logic [15:0]      clearAll;
   logic [INT_W-1:0] intSet;
   logic [INT_W-1:0] intClr;
   logic [INT_W-1:0] intStatus;
   logic             codeValid;
   logic [15:0]      codeValue;
   logic             mapped;
   logic             setupRd;
   logic             accWr;
   logic             accRd;
   logic             errClear;

   // Detector mapping onto the fatal word.
   always_comb begin
      fatalSet               = '0;
      fatalSet[FAT_ALARM]    = fatalAlarmExec;
      fatalSet[FAT_CYCLE]    = cycleDone && (cycleTimeMeas > st.limit_reg);
      fatalSet[FAT_PROG]     = programInvalid;
      fatalSet[FAT_IOSET]    = motionModuleCount > MAX_MOTION_MODULES;
      fatalSet[FAT_MISMATCH] = ioModelMismatch;
      fatalSet[FAT_DUP]      = cpuBusUnitDup | specialIoUnitDup | basicIoWordDup;
      fatalSet[FAT_IOBUS]    = ioBusTransferErr;
      fatalSet[FAT_MEM]      = memoryErr;
   end

   // Detector mapping onto the non-fatal word.
   always_comb begin
      nonfatalSet             = '0;
      nonfatalSet[NF_MMON]    = motionModuleSysErr;
      nonfatalSet[NF_SPIO]    = specialIoExchErr;
      nonfatalSet[NF_CPUBUS]  = cpuBusExchErr;
      nonfatalSet[NF_CMWDT]   = st.role_reg & coordWatchdogTimeout;
      nonfatalSet[NF_SETUP]   = setupParamErr;
      nonfatalSet[NF_CMFATAL] = st.role_reg & coordFatalErr;
      nonfatalSet[NF_ALARM]   = nonfatalAlarmExec;
   end

   // APB decode; every access completes without wait states.
   always_comb begin
      mapped   = hit(paddr, IDX_TERM) | hit(paddr, IDX_CODE) | hit(paddr, IDX_FATAL) |
                 hit(paddr, IDX_NONFATAL) | hit(paddr, IDX_CTRL) | hit(paddr, IDX_LIMIT) |
                 hit(paddr, IDX_ISTAT) | hit(paddr, IDX_IMASK);
      setupRd  = psel & ~penable & ~pwrite;
      accWr    = psel & penable & pwrite & mapped;
      accRd    = psel & penable & ~pwrite & mapped;
      errClear = accWr & hit(paddr, IDX_CTRL) & pwdata[CTRL_CLR];
      clearAll = {16{errClear}};
      pready   = 1'b1;
      pslverr  = psel & penable & ~mapped;
   end

   esf_sticky_flags #(
      .W       (16)
   ) u_fatal (
      .clk     (clk),
      .reset   (reset),
      .setBits (fatalSet),
      .clrBits (clearAll),
      .flags   (fatalFlags)
   );

   esf_sticky_flags #(
      .W       (16)
   ) u_nonfatal (
      .clk     (clk),
      .reset   (reset),
      .setBits (nonfatalSet),
      .clrBits (clearAll),
      .flags   (nonfatalFlags)
   );

   // Interrupt events are fresh flag rises; a status read clears only the bits it returned,
   // so an event landing between setup and access is kept for the next read.
   always_comb begin
      intSet               = '0;
      intSet[INT_FATAL]    = |(fatalSet & ~fatalFlags);
      intSet[INT_NONFATAL] = |(nonfatalSet & ~nonfatalFlags);
      intClr               = (accRd && hit(paddr, IDX_ISTAT)) ? st.icapt_reg : '0;
   end

   esf_sticky_flags #(
      .W       (INT_W)
   ) u_int (
      .clk     (clk),
      .reset   (reset),
      .setBits (intSet),
      .clrBits (intClr),
      .flags   (intStatus)
   );

   esf_code_pick u_code (
      .newFatal          (fatalSet & ~fatalFlags),
      .newNonfatal       (nonfatalSet & ~nonfatalFlags),
      .fatalAlarmCode    (fatalAlarmCode),
      .nonfatalAlarmCode (nonfatalAlarmCode),
      .codeValid         (codeValid),
      .codeValue         (codeValue)
   );

   always_comb begin
      st_next = st;
      st_next.term_reg[7:0] = terminalLinkMode ? terminalActive : 8'h00;
      st_next.term_reg[15:8] = 8'h00;
      if (terminalLinkMode && priorityValid) begin
         st_next.term_reg[8 + 32'(priorityUnit)] = 1'b1;
      end
      if (codeValid) begin
         st_next.code_reg = codeValue;
      end
      // Halt follows a stopping fatal error; an error clear resumes unless one recurs.
      case (st.run_reg)
         ESF_RUN: begin
            if (|(fatalSet & FATAL_STOP_MASK)) begin
               st_next.run_reg = ESF_HALT;
            end
         end
         ESF_HALT: begin
            if (errClear && !(|(fatalSet & FATAL_STOP_MASK))) begin
               st_next.run_reg = ESF_RUN;
            end
         end
         default: begin
            st_next.run_reg = ESF_HALT;
         end
      endcase
      if (accWr && hit(paddr, IDX_CTRL)) begin
         st_next.role_reg = pwdata[CTRL_ROLE];
      end
      if (accWr && hit(paddr, IDX_LIMIT)) begin
         st_next.limit_reg = pwdata[15:0];
      end
      if (accWr && hit(paddr, IDX_IMASK)) begin
         st_next.imask_reg = pwdata[INT_W-1:0];
      end
      // Read data is captured in the setup cycle; status words ignore writes.
      if (setupRd) begin
         st_next.prdata_reg = 32'h0000_0000;
         st_next.icapt_reg  = '0;
         if (hit(paddr, IDX_TERM)) begin
            st_next.prdata_reg = {16'h0000, st.term_reg};
         end else if (hit(paddr, IDX_CODE)) begin
            st_next.prdata_reg = {16'h0000, st.code_reg};
         end else if (hit(paddr, IDX_FATAL)) begin
            st_next.prdata_reg = {16'h0000, fatalFlags};
         end else if (hit(paddr, IDX_NONFATAL)) begin
            st_next.prdata_reg = {16'h0000, nonfatalFlags};
         end else if (hit(paddr, IDX_CTRL)) begin
            st_next.prdata_reg = {30'h0000_0000, st.role_reg, 1'b0};
         end else if (hit(paddr, IDX_LIMIT)) begin
            st_next.prdata_reg = {16'h0000, st.limit_reg};
         end else if (hit(paddr, IDX_ISTAT)) begin
            st_next.prdata_reg = {30'h0000_0000, intStatus};
            st_next.icapt_reg  = intStatus;
         end else if (hit(paddr, IDX_IMASK)) begin
            st_next.prdata_reg = {30'h0000_0000, st.imask_reg};
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         st.prdata_reg <= 32'h0000_0000;
         st.term_reg   <= RST_FLAGS;
         st.code_reg   <= RST_CODE;
         st.role_reg   <= 1'b0;
         st.limit_reg  <= RST_LIMIT;
         st.imask_reg  <= RST_MASK;
         st.icapt_reg  <= '0;
         st.run_reg    <= ESF_RUN;
      end else begin
         st <= st_next;
      end
   end

   assign prdata        = st.prdata_reg;
   assign stopOperation = (st.run_reg == ESF_HALT);
   assign errIndicator  = fatalFlags[FAT_MEM];
   assign irq           = |(intStatus & st.imask_reg);

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (reset);

   fatal_alarm_set_a: assert property (fatalAlarmExec
         |=> fatalFlags[FAT_ALARM] && stopOperation)
      else $error("Fatal alarm did not set its flag and halt.");
   cycle_overrun_a: assert property (cycleDone && cycleTimeMeas > st.limit_reg
         |=> fatalFlags[FAT_CYCLE])
      else $error("Cycle overrun flag missing.");
   cycle_equal_a: assert property (cycleDone && cycleTimeMeas == st.limit_reg
         && !fatalFlags[FAT_CYCLE] |=> !fatalFlags[FAT_CYCLE])
      else $error("Cycle time at the limit was flagged.");
   program_halt_a: assert property (programInvalid
         |=> fatalFlags[FAT_PROG] && stopOperation)
      else $error("Program error did not halt.");
   module_count_a: assert property (motionModuleCount == 4'h5
         |=> fatalFlags[FAT_IOSET])
      else $error("Module count flag missing.");
   four_modules_a: assert property (motionModuleCount == 4'h4 && !fatalFlags[FAT_IOSET]
         && !errClear |=> !fatalFlags[FAT_IOSET])
      else $error("Four modules wrongly flagged.");
   model_mismatch_a: assert property (ioModelMismatch
         |=> fatalFlags[FAT_MISMATCH])
      else $error("Model mismatch flag missing.");
   dup_any_a: assert property (basicIoWordDup
         |=> fatalFlags[FAT_DUP])
      else $error("Duplication flag missing.");
   dup_unit_a: assert property (cpuBusUnitDup || specialIoUnitDup
         |=> fatalFlags[FAT_DUP])
      else $error("Unit number duplication flag missing.");
   transfer_halt_a: assert property (ioBusTransferErr
         |=> fatalFlags[FAT_IOBUS] && stopOperation)
      else $error("Transfer error did not halt.");
   mem_indicator_a: assert property (memoryErr && !fatalFlags[FAT_MEM]
         |=> errIndicator && stopOperation && st.code_reg == (CODE_FATAL_BASE | 16'h000f))
      else $error("Memory error not reported.");
   monitor_err_a: assert property (motionModuleSysErr
         |=> nonfatalFlags[NF_MMON])
      else $error("Module monitoring flag missing.");
   special_exch_a: assert property (specialIoExchErr
         |=> nonfatalFlags[NF_SPIO])
      else $error("Special unit exchange flag missing.");
   bus_exch_a: assert property (cpuBusExchErr
         |=> nonfatalFlags[NF_CPUBUS])
      else $error("Bus unit exchange flag missing.");
   coord_wdt_a: assert property (st.role_reg && coordWatchdogTimeout
         |=> nonfatalFlags[NF_CMWDT])
      else $error("Coordinator watchdog flag missing.");
   role_gate_a: assert property (!st.role_reg && coordWatchdogTimeout
         && !nonfatalFlags[NF_CMWDT] |=> !nonfatalFlags[NF_CMWDT])
      else $error("Coordinator watchdog flag set outside a motion module.");
   setup_err_a: assert property (setupParamErr
         |=> nonfatalFlags[NF_SETUP])
      else $error("Setup error flag missing.");
   coord_fatal_a: assert property (st.role_reg && coordFatalErr
         |=> nonfatalFlags[NF_CMFATAL])
      else $error("Coordinator fatal flag missing.");
   fatal_gate_a: assert property (!st.role_reg && coordFatalErr
         && !nonfatalFlags[NF_CMFATAL] |=> !nonfatalFlags[NF_CMFATAL])
      else $error("Coordinator fatal flag set outside a motion module.");
   nf_alarm_run_a: assert property (nonfatalAlarmExec && !fatalFlags[FAT_ALARM]
         && !stopOperation && fatalSet == 16'h0000 |=> nonfatalFlags[NF_ALARM] && !stopOperation)
      else $error("Non-fatal alarm misbehaved.");
   fatal_code_a: assert property (fatalAlarmExec && !fatalFlags[FAT_ALARM]
         && fatalSet[15:7] == 9'h000 |=> st.code_reg == $past(fatalAlarmCode))
      else $error("Fatal alarm code not recorded.");
   nf_code_a: assert property (nonfatalAlarmExec && !nonfatalFlags[NF_ALARM]
         && (fatalSet & ~fatalFlags) == 16'h0000 |=> st.code_reg == $past(nonfatalAlarmCode))
      else $error("Non-fatal alarm code not recorded.");
   term_low_a: assert property (terminalLinkMode
         |=> st.term_reg[7:0] == $past(terminalActive))
      else $error("Terminal link bits wrong.");
   link_off_a: assert property (!terminalLinkMode
         |=> st.term_reg == 16'h0000)
      else $error("Terminal word not empty outside link mode.");
   term_prio_a: assert property (terminalLinkMode && priorityValid
         |=> $onehot(st.term_reg[15:8]))
      else $error("Priority byte not one-hot.");
   sticky_hold_a: assert property (!errClear
         |=> (fatalFlags & $past(fatalFlags)) == $past(fatalFlags))
      else $error("Fatal flag dropped without clear.");
   err_clear_a: assert property (errClear && fatalSet == 16'h0000
         |=> fatalFlags == 16'h0000)
      else $error("Error clear left a fatal flag.");

   // Main scenarios: halt and resume, interrupt service, priority, clear, alarm race.
   halt_cover_c: cover property (fatalAlarmExec ##1 stopOperation ##[1:20] !stopOperation);
   irq_cover_c: cover property (irq ##[1:10] !irq);
   prio_cover_c: cover property (terminalLinkMode && priorityValid ##1 st.term_reg[15]);
   clear_cover_c: cover property (errClear && stopOperation
         ##1 !stopOperation);
   both_alarms_c: cover property (fatalAlarmExec && nonfatalAlarmExec
         ##1 stopOperation);
endmodule : esf_status_bank
`default_nettype wire

// >>> verification/esf_status_bank_bench.sv
// Self-checking bench for the error, flag and terminal status bank.
`timescale 1ns/1ns
`default_nettype none
module esf_status_bank_bench;
   import esf_pkg::*;
   logic clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, stopOperation, errIndicator, irq;
   logic terminalLinkMode = 1'b1, priorityValid = 1'b1, cycleDone = 1'b0;
   logic [7:0] terminalActive = 8'h00;
   logic [2:0] priorityUnit = 3'h0;
   logic fatalAlarmExec = 1'b0, nonfatalAlarmExec = 1'b0, programInvalid = 1'b0;
   logic [15:0] fatalAlarmCode = 16'h0000, nonfatalAlarmCode = 16'h0000, cycleTimeMeas = 16'h0000;
   logic [3:0] motionModuleCount = 4'h4;
   logic ioModelMismatch = 1'b0, cpuBusUnitDup = 1'b0, specialIoUnitDup = 1'b0;
   logic basicIoWordDup = 1'b0, ioBusTransferErr = 1'b0, memoryErr = 1'b0;
   logic motionModuleSysErr = 1'b0, specialIoExchErr = 1'b0, cpuBusExchErr = 1'b0;
   logic coordWatchdogTimeout = 1'b0, setupParamErr = 1'b0, coordFatalErr = 1'b0;
   int mismatches = 0, checked = 0;
   logic [31:0] rdata;
   logic err;
   logic [15:0] expCode, fe, ne, c1, lim;
   logic [7:0] act;
   logic [2:0] unit;
   int bitOf[14] = '{9, 11, 13, 13, 13, 14, 15, 10, 5, 6, 7, 8, 10, 14};

   esf_status_bank esf_status_bank_i (.clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .terminalLinkMode, .terminalActive, .priorityValid,
      .priorityUnit, .fatalAlarmExec, .fatalAlarmCode, .nonfatalAlarmExec, .nonfatalAlarmCode,
      .cycleDone, .cycleTimeMeas, .programInvalid, .motionModuleCount, .ioModelMismatch,
      .cpuBusUnitDup, .specialIoUnitDup, .basicIoWordDup, .ioBusTransferErr, .memoryErr,
      .motionModuleSysErr, .specialIoExchErr, .cpuBusExchErr, .coordWatchdogTimeout,
      .setupParamErr, .coordFatalErr, .stopOperation, .errIndicator, .irq);

   initial begin
      forever #2 clk = ~clk;
   end

   task automatic test_done;
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : test_done

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic chkBit(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask : chkBit

   // The master never assumes a wait count; only the watchdog ends a hung access.
   task automatic apb(input logic w, input logic [9:0] idx, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) begin
         @(posedge clk);
      end
      rdata = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0);
      chk(rdata, exp);
   endtask : rd

   task automatic clr(input logic role);
      apb(1'b1, IDX_CTRL, {30'h0, role, 1'b1});
   endtask : clr

   task automatic drive(input int k, input logic v);
      case (k)
         0: programInvalid <= v;
         1: ioModelMismatch <= v;
         2: cpuBusUnitDup <= v;
         3: specialIoUnitDup <= v;
         4: basicIoWordDup <= v;
         5: ioBusTransferErr <= v;
         6: memoryErr <= v;
         7: motionModuleCount <= v ? 4'h5 : 4'h4;
         8: motionModuleSysErr <= v;
         9: specialIoExchErr <= v;
         10: cpuBusExchErr <= v;
         11: coordWatchdogTimeout <= v;
         12: setupParamErr <= v;
         13: coordFatalErr <= v;
         14: cycleDone <= v;
         15: fatalAlarmExec <= v;
         16: nonfatalAlarmExec <= v;
         default: ;
      endcase
   endtask : drive

   task automatic pulse(input int k);
      @(posedge clk);
      drive(k, 1'b1);
      @(posedge clk);
      drive(k, 1'b0);
   endtask : pulse

   function automatic logic [15:0] sysCode(input int k);
      return (k < 8 ? CODE_FATAL_BASE : CODE_NONFATAL_BASE) | 16'(bitOf[k]);
   endfunction : sysCode

   initial begin
      repeat (6) @(posedge clk);
      reset <= 1'b0;
      void'($urandom(69102));
      rd(IDX_CODE, 32'h0);
      rd(IDX_FATAL, 32'h0);
      rd(IDX_NONFATAL, 32'h0);
      rd(IDX_LIMIT, {16'h0, RST_LIMIT});
      rd(IDX_IMASK, 32'h0);
      apb(1'b0, 10'h3ff, 32'h0);
      chkBit(err, 1'b1);
      chk(rdata, 32'h0);
      $display("test reset done");
      repeat (4) begin
         act = 8'($urandom);
         unit = 3'($urandom);
         terminalActive <= act;
         priorityUnit <= unit;
         rd(IDX_TERM, {16'h0, 8'h01 << unit, act});
      end
      terminalLinkMode <= 1'b0;
      rd(IDX_TERM, 32'h0);
      terminalLinkMode <= 1'b1;
      priorityValid <= 1'b0;
      rd(IDX_TERM, {16'h0, 8'h00, act});
      priorityValid <= 1'b1;
      $display("test terminal done");
      expCode = 16'h0000;
      for (int r = 0; r < 2; r++) begin
         for (int k = 0; k < 14; k++) begin
            clr(r[0]);
            pulse(k);
            fe = (k < 8) ? 16'h1 << bitOf[k] : 16'h0;
            ne = (k >= 8 && (r == 1 || (k != 11 && k != 13))) ? 16'h1 << bitOf[k] : 16'h0;
            if ((fe | ne) != 16'h0) expCode = sysCode(k);
            rd(IDX_FATAL, {16'h0, fe});
            rd(IDX_NONFATAL, {16'h0, ne});
            rd(IDX_CODE, {16'h0, expCode});
            chkBit(stopOperation, |(fe & FATAL_STOP_MASK));
            chkBit(errIndicator, fe[15]);
         end
      end
      rd(IDX_CTRL, 32'h2);
      $display("test detectors done");
      lim = {1'b0, 15'($urandom)};
      clr(1'b0);
      apb(1'b1, IDX_LIMIT, {16'h0, lim});
      cycleTimeMeas <= lim;
      pulse(14);
      rd(IDX_FATAL, 32'h0);
      cycleTimeMeas <= lim + 16'h0001;
      pulse(14);
      rd(IDX_FATAL, 32'h100);
      rd(IDX_CODE, {16'h0, CODE_FATAL_BASE | 16'h0008});
      $display("test cycle limit done");
      c1 = 16'($urandom);
      clr(1'b0);
      fatalAlarmCode <= c1;
      pulse(15);
      rd(IDX_FATAL, 32'h40);
      rd(IDX_CODE, {16'h0, c1});
      chkBit(stopOperation, 1'b1);
      fatalAlarmCode <= ~c1;
      pulse(15);
      rd(IDX_CODE, {16'h0, c1});
      apb(1'b1, IDX_FATAL, 32'h0);
      rd(IDX_FATAL, 32'h40);
      clr(1'b0);
      nonfatalAlarmCode <= c1 ^ 16'h5a5a;
      pulse(16);
      rd(IDX_NONFATAL, 32'h8000);
      rd(IDX_CODE, {16'h0, c1 ^ 16'h5a5a});
      chkBit(stopOperation, 1'b0);
      // Both alarms in one cycle: the fatal code has to win the word.
      clr(1'b0);
      fatalAlarmCode <= c1;
      @(posedge clk);
      drive(15, 1'b1);
      drive(16, 1'b1);
      @(posedge clk);
      drive(15, 1'b0);
      drive(16, 1'b0);
      rd(IDX_CODE, {16'h0, c1});
      $display("test alarms done");
      rd(IDX_ISTAT, 32'h3);
      apb(1'b1, IDX_IMASK, 32'h2);
      rd(IDX_IMASK, 32'h2);
      clr(1'b0);
      pulse(1);
      rd(IDX_FATAL, 32'h800);
      chkBit(irq, 1'b0);
      clr(1'b0);
      pulse(8);
      rd(IDX_NONFATAL, 32'h20);
      chkBit(irq, 1'b1);
      rd(IDX_ISTAT, 32'h3);
      rd(IDX_ISTAT, 32'h0);
      chkBit(irq, 1'b0);
      $display("test interrupt done");
      test_done();
   end

   initial begin
      #100000;
      mismatches++;
      test_done();
   end
endmodule : esf_status_bank_bench
`default_nettype wire
